// file: core/psf_formatter.sv
// Printer stream formatter: channel fetch, unpacking and format decoding
`timescale 1ns/1ps
`default_nettype none
`include "psf_map.svh"
module psf_formatter #(
   parameter int FIFO_DEPTH = 4,
   parameter logic [7:0] LINES_PER_FORM = `PSF_LINES_PER_FORM
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Host instruction port
   input wire logic instr_valid_i,
   input wire logic [2:0] instr_op_i,
   input wire logic [1:0] instr_flag_i,
   input wire logic [15:0] instr_data_i,
   output logic [15:0] instr_rdata_o,
   output logic busy_o,
   output logic done_o,
   output logic prog_irq_o,
   // Data channel
   output logic dch_req_o,
   output logic [14:0] dch_addr_o,
   input wire logic dch_ack_i,
   input wire logic [15:0] dch_data_i,
   output logic dch_irq_o,
   // Printer
   output logic prn_strobe_o,
   output logic [7:0] prn_data_o,
   input wire logic prn_accept_i,
   output logic prn_paper_step_o,
   output logic prn_chan_sel_o,
   output logic [3:0] prn_chan_o,
   input wire logic prn_chan_done_i,
   input wire logic prn_ready_i,
   input wire logic prn_online_i
);
   psf_pkg::psf_state_t state_reg;
   logic [15:0] remaining_byte_count_reg;
   logic [14:0] addr_reg;
   logic byte_ptr_reg;
   logic fmt_disable_reg;
   logic runaway_reg;
   logic change_reg;
   logic ready_q_reg;
   logic online_q_reg;
   logic [255:0] tab_mem_reg;
   logic tab_loaded_reg;
   logic tab_loading_reg;
   logic [7:0] tab_wr_col_reg;
   logic [7:0] column_reg;
   logic [7:0] line_reg;
   logic [7:0] steps_reg;
   logic dc2_seen_reg;
   logic fetch_pending_reg;
   logic [7:0] cur_byte;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [15:0] fifo_out_data;
   logic last_byte;
   logic half_reg;
   logic status_edge;
   logic host_start;
   logic host_clear;
   logic [7:0] vf_cmd;

   // Flag function of an instruction decoded once for all users
   function automatic logic flag_is(input logic [1:0] f, input logic [1:0] want);
      flag_is = instr_valid_i && (f == want);
   endfunction

   assign host_start = flag_is(instr_flag_i, `PSF_FLAG_START);
   assign host_clear = flag_is(instr_flag_i, `PSF_FLAG_CLEAR);
   assign status_edge = (prn_ready_i != ready_q_reg) || (prn_online_i != online_q_reg);
   assign cur_byte = half_reg ? fifo_out_data[7:0] : fifo_out_data[15:8];
   assign last_byte = (remaining_byte_count_reg == 16'hFFFF);
   assign vf_cmd = {1'b1, cur_byte[6:0]};

   // Word buffer; start flushes words prefetched past the end of the last block
   psf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .flush_i(host_clear || host_start),
      .in_valid_i(dch_ack_i && fetch_pending_reg),
      .in_ready_o(fifo_in_ready),
      .in_data_i(dch_data_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data)
   );

   // Register file reached by instructions
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         fmt_disable_reg <= 1'b1;
         instr_rdata_o <= 16'h0000;
      end else if (instr_valid_i) begin
         case (instr_op_i)
            `PSF_OP_WRITE_FMT: fmt_disable_reg <= instr_data_i[15];
            `PSF_OP_READ_COUNT: instr_rdata_o <= remaining_byte_count_reg;
            `PSF_OP_READ_ADDR: instr_rdata_o <= {byte_ptr_reg, addr_reg};
            `PSF_OP_READ_FLAGS: instr_rdata_o <= {12'h000, runaway_reg, change_reg,
               prn_ready_i, prn_online_i};
            default: instr_rdata_o <= instr_rdata_o;
         endcase
      end
   end

   // Status line monitor
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ready_q_reg <= prn_ready_i; // Track the lines in reset so release shows no false change
         online_q_reg <= prn_online_i;
         change_reg <= 1'b0;
         runaway_reg <= 1'b0;
         prog_irq_o <= 1'b0;
      end else begin
         ready_q_reg <= prn_ready_i;
         online_q_reg <= prn_online_i;
         // Set wins over clear so no event is lost
         if (status_edge) begin
            change_reg <= 1'b1;
         end else if (host_clear) begin
            change_reg <= 1'b0;
         end
         if (state_reg == psf_pkg::PSF_UNPACK && fifo_out_valid && !dc2_seen_reg &&
             !tab_loading_reg && !fmt_disable_reg && cur_byte == `PSF_CH_HT &&
             !tab_loaded_reg) begin
            runaway_reg <= 1'b1;
         end else if (host_clear) begin
            runaway_reg <= 1'b0;
         end
         prog_irq_o <= (change_reg || runaway_reg) && !host_clear;
      end
   end

   // Busy, done, counters and the stream engine
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_reg <= psf_pkg::PSF_IDLE;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         remaining_byte_count_reg <= 16'h0000;
         addr_reg <= 15'h0000;
         byte_ptr_reg <= 1'b0;
         half_reg <= 1'b0;
         fetch_pending_reg <= 1'b0;
         dch_req_o <= 1'b0;
         dch_addr_o <= 15'h0000;
         dch_irq_o <= 1'b0;
         prn_strobe_o <= 1'b0;
         prn_data_o <= 8'h00;
         prn_paper_step_o <= 1'b0;
         prn_chan_sel_o <= 1'b0;
         prn_chan_o <= 4'h0;
         dc2_seen_reg <= 1'b0;
         tab_loading_reg <= 1'b0;
         tab_loaded_reg <= 1'b0;
         tab_wr_col_reg <= `PSF_FIRST_COLUMN;
         column_reg <= `PSF_FIRST_COLUMN;
         line_reg <= 8'h00;
         steps_reg <= 8'h00;
         fifo_pop <= 1'b0;
      end else begin
         fifo_pop <= 1'b0;
         prn_paper_step_o <= 1'b0;
         if (instr_valid_i && instr_op_i == `PSF_OP_LOAD_ADDR) begin
            addr_reg <= instr_data_i[15:1];
            byte_ptr_reg <= instr_data_i[0];
         end
         if (instr_valid_i && instr_op_i == `PSF_OP_LOAD_COUNT) begin
            remaining_byte_count_reg <= instr_data_i;
         end
         if (host_clear) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            state_reg <= psf_pkg::PSF_IDLE;
            dch_req_o <= 1'b0;
            fetch_pending_reg <= 1'b0;
            prn_strobe_o <= 1'b0;
            prn_chan_sel_o <= 1'b0;
         end else if (host_start) begin
            busy_o <= 1'b1;
            done_o <= 1'b0;
            half_reg <= byte_ptr_reg;
            dch_irq_o <= 1'b0;
            state_reg <= psf_pkg::PSF_FETCH;
         end else begin
            // Fetch words ahead while the buffer has room
            if (busy_o && !fetch_pending_reg && fifo_in_ready &&
                state_reg != psf_pkg::PSF_IDLE) begin
               dch_req_o <= 1'b1;
               dch_addr_o <= addr_reg;
               fetch_pending_reg <= 1'b1;
            end else if (fetch_pending_reg && dch_ack_i) begin
               dch_req_o <= 1'b0;
               fetch_pending_reg <= 1'b0;
               addr_reg <= addr_reg + 15'h0001;
            end
            case (state_reg)
               psf_pkg::PSF_FETCH: state_reg <= psf_pkg::PSF_UNPACK;
               psf_pkg::PSF_UNPACK: begin
                  if (fifo_out_valid && !fifo_pop) begin
                     remaining_byte_count_reg <= remaining_byte_count_reg + 16'h0001;
                     half_reg <= !half_reg;
                     fifo_pop <= half_reg;
                     if (last_byte) begin
                        dch_irq_o <= 1'b1;
                     end
                     state_reg <= psf_pkg::PSF_EMIT;
                     if (dc2_seen_reg) begin
                        dc2_seen_reg <= 1'b0;
                        column_reg <= `PSF_FIRST_COLUMN;
                        if (vf_cmd[`PSF_VF_TYPE_BIT]) begin
                           steps_reg <= {4'h0, vf_cmd[3:0]};
                           if ({4'h0, vf_cmd[3:0]} > LINES_PER_FORM - line_reg) begin
                              steps_reg <= (LINES_PER_FORM - line_reg) +
                                 {4'h0, vf_cmd[3:0]};
                           end
                           state_reg <= psf_pkg::PSF_ADVANCE;
                        end else begin
                           prn_chan_sel_o <= 1'b1;
                           prn_chan_o <= vf_cmd[3:0];
                           state_reg <= psf_pkg::PSF_ADVANCE;
                        end
                     end else if (tab_loading_reg) begin
                        if (cur_byte == `PSF_CH_DC1) begin
                           tab_loading_reg <= 1'b0;
                           tab_loaded_reg <= 1'b1;
                        end else begin
                           tab_mem_reg[tab_wr_col_reg] <= cur_byte[0];
                           tab_wr_col_reg <= tab_wr_col_reg + 8'h01;
                        end
                        state_reg <= psf_pkg::PSF_EMIT; // Block-end test lives in EMIT
                     end else if (!fmt_disable_reg && cur_byte == `PSF_CH_DLE) begin
                        tab_loading_reg <= 1'b1;
                        tab_wr_col_reg <= `PSF_FIRST_COLUMN;
                        state_reg <= psf_pkg::PSF_EMIT;
                     end else if (!fmt_disable_reg && cur_byte == `PSF_CH_DC2) begin
                        dc2_seen_reg <= 1'b1;
                        state_reg <= psf_pkg::PSF_EMIT;
                     end else if (cur_byte == `PSF_CH_HT && !fmt_disable_reg) begin
                        if (!tab_loaded_reg) begin
                           done_o <= 1'b1;
                           busy_o <= 1'b0;
                           state_reg <= psf_pkg::PSF_IDLE;
                        end else begin
                           state_reg <= psf_pkg::PSF_TAB;
                        end
                     end else begin
                        prn_strobe_o <= 1'b1;
                        prn_data_o <= cur_byte;
                        if (cur_byte == `PSF_CH_CR || cur_byte == `PSF_CH_LF) begin
                           column_reg <= `PSF_FIRST_COLUMN;
                           if (cur_byte == `PSF_CH_LF) begin
                              line_reg <= (line_reg == LINES_PER_FORM - 8'h01) ? 8'h00 :
                                 line_reg + 8'h01;
                           end
                        end else if (cur_byte == `PSF_CH_FF) begin
                           column_reg <= `PSF_FIRST_COLUMN;
                           line_reg <= 8'h00;
                        end else begin
                           column_reg <= column_reg + 8'h01;
                        end
                     end
                  end
               end
               psf_pkg::PSF_EMIT: begin
                  if (!prn_strobe_o || prn_accept_i) begin
                     prn_strobe_o <= 1'b0;
                     state_reg <= (remaining_byte_count_reg == 16'h0000) ?
                        psf_pkg::PSF_IDLE : psf_pkg::PSF_UNPACK;
                     if (remaining_byte_count_reg == 16'h0000) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                     end
                  end
               end
               psf_pkg::PSF_TAB: begin
                  // One space per accepted strobe; a full-width scan with no stop ends the tab
                  if (!prn_strobe_o || prn_accept_i) begin
                     if (tab_mem_reg[column_reg - 8'h01] && column_reg != `PSF_FIRST_COLUMN ||
                         column_reg == 8'hFF) begin
                        prn_strobe_o <= 1'b0;
                        state_reg <= psf_pkg::PSF_EMIT;
                     end else begin
                        prn_strobe_o <= 1'b1;
                        prn_data_o <= `PSF_CH_SPACE;
                        column_reg <= column_reg + 8'h01;
                     end
                  end
               end
               psf_pkg::PSF_ADVANCE: begin
                  if (prn_chan_sel_o) begin
                     if (prn_chan_done_i) begin
                        prn_chan_sel_o <= 1'b0;
                        state_reg <= psf_pkg::PSF_EMIT;
                     end
                  end else if (steps_reg != 8'h00) begin
                     prn_paper_step_o <= 1'b1;
                     steps_reg <= steps_reg - 8'h01;
                     line_reg <= (line_reg == LINES_PER_FORM - 8'h01) ? 8'h00 :
                        line_reg + 8'h01;
                  end else begin
                     state_reg <= psf_pkg::PSF_EMIT;
                  end
               end
               default: state_reg <= psf_pkg::PSF_IDLE;
            endcase
         end
      end
   end

   a_count_step: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_reg == psf_pkg::PSF_UNPACK && fifo_out_valid && !fifo_pop && !host_clear &&
      !host_start |=> remaining_byte_count_reg == $past(remaining_byte_count_reg) + 16'h0001)
      else $error("byte counter did not advance");
   a_start_flags: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      host_start && !host_clear |=> busy_o && !done_o)
      else $error("start did not set busy");
   a_clear_flags: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      host_clear && !status_edge |=> !busy_o && !done_o && !change_reg)
      else $error("clear left flags set");
   a_status_change: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      status_edge |=> change_reg ##1 (prog_irq_o || $past(host_clear)))
      else $error("status change missed");
   a_count_read: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      instr_valid_i && instr_op_i == `PSF_OP_READ_COUNT |=>
      instr_rdata_o == $past(remaining_byte_count_reg))
      else $error("read count mismatch");
   a_reset_fmt: assert property (@(posedge sys_clk_i)
      !resetn_i |=> fmt_disable_reg)
      else $error("reset left formatting on");
   a_high_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      host_start && !host_clear && !byte_ptr_reg |=> !half_reg)
      else $error("did not start on high byte");
   a_low_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      host_start && !host_clear && byte_ptr_reg |=> half_reg)
      else $error("byte selector ignored");
endmodule
`default_nettype wire

// file: pkg/psf_map.svh
// Constants for the printer stream formatter
`ifndef PSF_MAP_SVH
`define PSF_MAP_SVH
`define PSF_CH_HT 8'h09
`define PSF_CH_LF 8'h0A
`define PSF_CH_FF 8'h0C
`define PSF_CH_CR 8'h0D
`define PSF_CH_DLE 8'h10
`define PSF_CH_DC1 8'h11
`define PSF_CH_DC2 8'h12
`define PSF_CH_SPACE 8'h20
`define PSF_FLAG_NONE 2'h0
`define PSF_FLAG_START 2'h1
`define PSF_FLAG_CLEAR 2'h2
`define PSF_FLAG_PULSE 2'h3
`define PSF_OP_READ_FLAGS 3'h0
`define PSF_OP_WRITE_FMT 3'h1
`define PSF_OP_LOAD_ADDR 3'h2
`define PSF_OP_LOAD_COUNT 3'h3
`define PSF_OP_READ_COUNT 3'h4
`define PSF_OP_READ_ADDR 3'h5
`define PSF_OP_NONE 3'h7
`define PSF_STAT_RUNAWAY 12
`define PSF_STAT_CHANGE 13
`define PSF_STAT_READY 14
`define PSF_STAT_ONLINE 15
`define PSF_VF_TYPE_BIT 4
`define PSF_VF_FORCE_BIT 7
`define PSF_LINES_PER_FORM 8'h42
`define PSF_FIRST_COLUMN 8'h01
`endif

// file: pkg/psf_pkg.sv
// Types for the printer stream formatter
package psf_pkg;
   typedef enum logic [2:0] {
      PSF_IDLE,
      PSF_FETCH,
      PSF_WAIT,
      PSF_UNPACK,
      PSF_EMIT,
      PSF_TAB,
      PSF_ADVANCE
   } psf_state_t;
endpackage

// file: core/psf_fifo.sv
// Small word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock, reset and flush
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || flush_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// file: tb/psf_host_printer_model.sv
// Host memory channel and printer mechanism model
`timescale 1ns/1ps
`default_nettype none
module psf_host_printer_model (
   // Clock
   input wire logic sys_clk_i,
   // Data channel
   input wire logic dch_req_i,
   input wire logic [14:0] dch_addr_i,
   output logic dch_ack_o,
   output logic [15:0] dch_data_o,
   // Printer
   input wire logic prn_strobe_i,
   input wire logic [7:0] prn_data_i,
   output logic prn_accept_o,
   input wire logic prn_paper_step_i,
   input wire logic prn_chan_sel_i,
   input wire logic [3:0] prn_chan_i,
   output logic prn_chan_done_o
);
   logic [15:0] mem [0:255];
   logic [7:0] got [$];
   int steps = 0;
   int chans = 0;
   int chan_code = 0;
   int wait_cnt = 0;
   int turn = 0;
   initial begin
      dch_ack_o = 1'b0;
      dch_data_o = 16'h0000;
      prn_accept_o = 1'b0;
      prn_chan_done_o = 1'b0;
   end
   // Every other answer is slow, so both prompt and late replies occur
   always @(posedge sys_clk_i) begin
      dch_ack_o <= 1'b0;
      prn_accept_o <= 1'b0;
      prn_chan_done_o <= 1'b0;
      dch_data_o <= ~dch_data_o;
      steps <= steps + int'(prn_paper_step_i);
      if ((dch_req_i || prn_strobe_i || prn_chan_sel_i) &&
          !(dch_ack_o || prn_accept_o || prn_chan_done_o)) begin
         if (wait_cnt < (turn % 2) * 3) begin
            wait_cnt <= wait_cnt + 1;
         end else begin
            wait_cnt <= 0;
            turn <= turn + 1;
            if (dch_req_i) begin
               dch_ack_o <= 1'b1;
               dch_data_o <= mem[dch_addr_i[7:0]];
            end else if (prn_strobe_i) begin
               prn_accept_o <= 1'b1;
               got.push_back(prn_data_i);
            end else begin
               prn_chan_done_o <= 1'b1;
               chans <= chans + 1;
               chan_code <= int'(prn_chan_i);
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/printer_stream_formatter_test.sv
// Self-checking bench for the printer stream formatter
`timescale 1ns/1ps
`default_nettype none
`include "psf_map.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module printer_stream_formatter_test;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [2:0] instr_op_i = `PSF_OP_NONE;
   logic [1:0] instr_flag_i = `PSF_FLAG_NONE;
   logic [15:0] instr_data_i = 16'h0000;
   logic prn_ready_i = 1'b1;
   logic prn_online_i = 1'b1;
   logic [15:0] instr_rdata_o, dch_data_i;
   logic busy_o, done_o, prog_irq_o, dch_req_o, dch_ack_i, dch_irq_o;
   logic [14:0] dch_addr_o;
   logic prn_strobe_o, prn_accept_i, prn_paper_step_o, prn_chan_sel_o, prn_chan_done_i;
   logic [7:0] prn_data_o;
   logic [3:0] prn_chan_o;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int s0, c0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   psf_formatter psf_formatter_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_flag_i(instr_flag_i),
      .instr_data_i(instr_data_i), .instr_rdata_o(instr_rdata_o), .busy_o(busy_o),
      .done_o(done_o), .prog_irq_o(prog_irq_o), .dch_req_o(dch_req_o),
      .dch_addr_o(dch_addr_o), .dch_ack_i(dch_ack_i), .dch_data_i(dch_data_i),
      .dch_irq_o(dch_irq_o), .prn_strobe_o(prn_strobe_o), .prn_data_o(prn_data_o),
      .prn_accept_i(prn_accept_i), .prn_paper_step_o(prn_paper_step_o),
      .prn_chan_sel_o(prn_chan_sel_o), .prn_chan_o(prn_chan_o),
      .prn_chan_done_i(prn_chan_done_i), .prn_ready_i(prn_ready_i),
      .prn_online_i(prn_online_i));
   psf_host_printer_model psf_host_printer_model_inst (.sys_clk_i(sys_clk_i),
      .dch_req_i(dch_req_o), .dch_addr_i(dch_addr_o), .dch_ack_o(dch_ack_i),
      .dch_data_o(dch_data_i), .prn_strobe_i(prn_strobe_o), .prn_data_i(prn_data_o),
      .prn_accept_o(prn_accept_i), .prn_paper_step_i(prn_paper_step_o),
      .prn_chan_sel_i(prn_chan_sel_o), .prn_chan_i(prn_chan_o),
      .prn_chan_done_o(prn_chan_done_i));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Bytes printed from index k on, right-aligned; a missing or extra byte shows
   function automatic logic [31:0] got_tail(input int k);
      got_tail = 32'h0;
      for (int i = k; i < psf_host_printer_model_inst.got.size(); i++) begin
         got_tail = {got_tail[23:0], psf_host_printer_model_inst.got[i]};
      end
   endfunction
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic ins(input logic [2:0] op, input logic [1:0] f, input logic [15:0] d);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b1;
      instr_op_i <= op;
      instr_flag_i <= f;
      instr_data_i <= d;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      instr_op_i <= `PSF_OP_NONE;
      instr_flag_i <= `PSF_FLAG_NONE;
      @(posedge sys_clk_i);
      #1;
   endtask
   // Done follows the last printed byte; a fetch may still be pending, hence the settling wait
   task automatic run(input logic [15:0] adr, input logic [15:0] cnt);
      int n;
      n = 0;
      psf_host_printer_model_inst.got.delete();
      ins(`PSF_OP_LOAD_ADDR, `PSF_FLAG_NONE, adr);
      ins(`PSF_OP_LOAD_COUNT, `PSF_FLAG_NONE, cnt);
      ins(`PSF_OP_READ_FLAGS, `PSF_FLAG_START, 16'h0000);
      `CHK("busy", 1'b1, busy_o)
      `CHK("done", 1'b0, done_o)
      while (done_o !== 1'b1 && n < 3000) begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (60) @(posedge sys_clk_i);
      #1;
      `CHK("finished", 1'b1, done_o)
   endtask
   task automatic t_plain();
      psf_host_printer_model_inst.mem[4] = 16'h4142;
      psf_host_printer_model_inst.mem[5] = 16'h4344;
      run(16'h0008, 16'hFFFC);
      `CHK("nbytes", 4, psf_host_printer_model_inst.got.size())
      `CHK("bytes", 32'h41424344, got_tail(0))
      `CHK("chan irq", 1'b1, dch_irq_o)
      `CHK("busy end", 1'b0, busy_o)
      ins(`PSF_OP_READ_COUNT, `PSF_FLAG_PULSE, 16'h0000);
      `CHK("count end", 16'h0000, instr_rdata_o)
      `CHK("pulse done", 1'b1, done_o)
   endtask
   task automatic t_selector();
      ins(`PSF_OP_LOAD_COUNT, `PSF_FLAG_NONE, 16'hFFFD);
      ins(`PSF_OP_READ_COUNT, `PSF_FLAG_NONE, 16'h0000);
      `CHK("count rd", 16'hFFFD, instr_rdata_o)
      ins(`PSF_OP_LOAD_ADDR, `PSF_FLAG_NONE, 16'h0009);
      ins(`PSF_OP_READ_ADDR, `PSF_FLAG_NONE, 16'h0000);
      `CHK("addr rd", 16'h8004, instr_rdata_o)
      run(16'h0009, 16'hFFFD);
      `CHK("bytes", 32'h00424344, got_tail(0))
   endtask
   task automatic t_runaway();
      psf_host_printer_model_inst.mem[8] = 16'h0920;
      ins(`PSF_OP_WRITE_FMT, `PSF_FLAG_NONE, 16'h0000);
      run(16'h0010, 16'hFFFF);
      `CHK("runaway irq", 1'b1, prog_irq_o)
      `CHK("runaway done", 1'b1, done_o)
      ins(`PSF_OP_NONE, `PSF_FLAG_CLEAR, 16'h0000);
      `CHK("clr irq", 1'b0, prog_irq_o)
      `CHK("clr done", 1'b0, done_o)
   endtask
   task automatic t_status();
      @(posedge sys_clk_i);
      prn_online_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1;
      `CHK("change irq", 1'b1, prog_irq_o)
      ins(`PSF_OP_NONE, `PSF_FLAG_CLEAR, 16'h0000);
      `CHK("change clr", 1'b0, prog_irq_o)
   endtask
   // All 256 tab bytes sent, stop only at column 3; after CR and A the tab fills 2 and 3
   task automatic t_tab();
      for (int i = 64; i < 195; i++) begin
         psf_host_printer_model_inst.mem[i] = 16'h3030;
      end
      psf_host_printer_model_inst.mem[64] = 16'h1030;
      psf_host_printer_model_inst.mem[65] = 16'h3031;
      psf_host_printer_model_inst.mem[192] = 16'h3011;
      psf_host_printer_model_inst.mem[193] = 16'h0D41;
      psf_host_printer_model_inst.mem[194] = 16'h0942;
      run(16'h0080, 16'hFEFA);
      `CHK("tab bytes", 5, psf_host_printer_model_inst.got.size())
      `CHK("tab tail", 32'h00202042, got_tail(2))
      `CHK("no runaway", 1'b0, prog_irq_o)
      ins(`PSF_OP_WRITE_FMT, `PSF_FLAG_NONE, 16'h8000);
   endtask
   task automatic t_vertical();
      s0 = psf_host_printer_model_inst.steps;
      c0 = psf_host_printer_model_inst.chans;
      ins(`PSF_OP_WRITE_FMT, `PSF_FLAG_NONE, 16'h0000);
      psf_host_printer_model_inst.mem[24] = 16'h1213;
      psf_host_printer_model_inst.mem[25] = 16'h127F;
      psf_host_printer_model_inst.mem[26] = 16'h1202;
      run(16'h0030, 16'hFFFA);
      `CHK("steps", 18, psf_host_printer_model_inst.steps - s0)
      `CHK("chan sel", 1, psf_host_printer_model_inst.chans - c0)
      `CHK("chan code", 2, psf_host_printer_model_inst.chan_code)
      `CHK("no vf bytes", 0, psf_host_printer_model_inst.got.size())
   endtask
   initial begin
      repeat (5) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_plain();
      t_selector();
      t_runaway();
      t_status();
      t_tab();
      t_vertical();
      report_and_stop();
   end
endmodule
`default_nettype wire
